// [pkg/updown_counter_pkg.sv]
// constants and carrier types for the four-bit up/down counter
// assumes a single clock domain and a plain register port
package updown_counter_pkg;

    localparam int          COUNT_WIDTH = 4;
    localparam logic [3:0]  COUNT_RESET = 4'h0;
    localparam logic [3:0]  COUNT_MIN   = 4'h0;
    localparam logic [3:0]  COUNT_MAX   = 4'hF;

    localparam int          ADDR_WIDTH  = 4;
    localparam logic [3:0]  REG_STATUS  = 4'h0;
    localparam logic [3:0]  REG_PRESET  = 4'h4;

    localparam int          STAT_COUNT_LSB = 0;
    localparam int          STAT_CARRY_BIT = 4;
    localparam int          STAT_UP_BIT    = 5;
    localparam int          STAT_SWLD_BIT  = 6;

    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef struct packed {
        logic       load_n;
        logic       enable_p_n;
        logic       enable_t_n;
        logic       up_down;
        logic [3:0] data;
    } ctrl_pins_t;

endpackage

// [core/count_step.sv]
// next-value and terminal-count logic for one counter stage
// assumes the caller registers the result on its own clock
`timescale 1ns/100ps

module count_step
    import updown_counter_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH
) (
    input  wire logic [WIDTH-1:0] count,
    input  wire logic             up_down,
    output logic      [WIDTH-1:0] stepped,
    output logic                  terminal
);

    // modulo wrap in both directions
    always_comb begin
        if (up_down) begin
            stepped  = WIDTH'(count + 1'b1);
            terminal = &count;
        end else begin
            stepped  = WIDTH'(count - 1'b1);
            terminal = ~|count;
        end
    end

endmodule

// [core/updown_counter.sv]
// four-bit synchronous presettable up/down binary counter
// assumes control pins come from logic on the same clock
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps

module updown_counter
    import updown_counter_pkg::*;
#(
    parameter int WIDTH = COUNT_WIDTH
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire ctrl_pins_t            pins,
    input  wire logic [ADDR_WIDTH-1:0] addr,
    input  wire logic [31:0]           wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [31:0]           rdata,
    output logic      [WIDTH-1:0]      count,
    output logic                       low_order_bit,
    output logic                       carry_n
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic [WIDTH-1:0] stepped;
    logic             terminal;
    logic             sw_load;
    logic [31:0]      rdata_reg;
    logic [31:0]      rdata_next;

    count_step #(
        .WIDTH    (WIDTH)
    ) u_step (
        .count    (count_reg),
        .up_down  (pins.up_down),
        .stepped  (stepped),
        .terminal (terminal)
    );

    assign sw_load = wr && (addr == REG_PRESET);

    // pin load first, then software preset, then counting
    always_comb begin
        if (!pins.load_n) begin
            count_next = pins.data[WIDTH-1:0];
        end else if (sw_load) begin
            count_next = wdata[WIDTH-1:0];
        end else if (!pins.enable_p_n && !pins.enable_t_n) begin
            count_next = stepped;
        end else begin
            count_next = count_reg;
        end
    end

    // count inputs sampled here, at the rising edge; reset_n clears count_reg asynchronously
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= COUNT_RESET[WIDTH-1:0];
        end else begin
            count_reg <= count_next;
        end
    end

    always_comb begin
        rdata_next = RDATA_RESET;
        if (rd) begin
            unique case (addr)
                REG_STATUS: begin
                    rdata_next[STAT_COUNT_LSB +: WIDTH] = count_reg;
                    rdata_next[STAT_CARRY_BIT]          = carry_n;
                    rdata_next[STAT_UP_BIT]             = pins.up_down;
                end
                REG_PRESET: begin
                    rdata_next[STAT_COUNT_LSB +: WIDTH] = count_reg;
                end
                default: begin
                    rdata_next = RDATA_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= RDATA_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata         = rdata_reg;
    assign count         = count_reg;
    assign low_order_bit = count_reg[0];

    // left combinational so direction changes reach the carry at once;
    // low for one clock when counting through the terminal value
    assign carry_n = ~(terminal && !pins.enable_t_n);

endmodule

// [testbench/updown_counter_asserts.sv]
// port checker for the up/down counter
// assumes one clock and the async active-low reset_n
`timescale 1ns/100ps
module updown_counter_asserts
    import updown_counter_pkg::*;
#(parameter int WIDTH = COUNT_WIDTH) (
    input wire logic             clk,
    input wire logic             reset_n,
    input wire ctrl_pins_t       pins,
    input wire logic             wr,
    input wire logic [WIDTH-1:0] count,
    input wire logic             low_order_bit,
    input wire logic             carry_n
);
    wire run  = pins.load_n && !wr && !pins.enable_p_n && !pins.enable_t_n;
    wire hold = pins.load_n && !wr && (pins.enable_p_n || pins.enable_t_n);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_load_copies: assert property (
        !pins.load_n |=> count == $past(pins.data)) else $error("load");
    a_hold_count: assert property (
        hold |=> $stable(count)) else $error("hold");
    a_step_up: assert property (
        run && pins.up_down |=> count == $past(count) + 1'b1) else $error("up");
    a_step_down: assert property (
        run && !pins.up_down |=> count == $past(count) - 1'b1)
        else $error("down");
    a_carry_gate: assert property (
        pins.enable_t_n |-> carry_n) else $error("gate");
    a_carry_max: assert property (
        !pins.enable_t_n && pins.up_down && count == 4'hF |-> !carry_n)
        else $error("max");
    a_carry_min: assert property (
        !pins.enable_t_n && !pins.up_down && count == 4'h0 |-> !carry_n)
        else $error("min");
    a_lsb_follow: assert property (low_order_bit == count[0])
        else $error("lsb");
endmodule
bind updown_counter updown_counter_asserts #(.WIDTH(WIDTH))
    updown_counter_asserts_i (.clk(clk), .reset_n(reset_n), .pins(pins),
    .wr(wr), .count(count), .low_order_bit(low_order_bit),
    .carry_n(carry_n));

// [testbench/cascade_stage_model.sv]
// next cascaded stage: steps while the lower carry is low
// assumes carry_n and direction share the counter clock
`timescale 1ns/100ps
module cascade_stage_model (
    input wire logic  clk,
    input wire logic  reset_n,
    input wire logic  carry_n,
    input wire logic  up_down,
    output logic [3:0] upper
);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            upper <= 4'h0;
        else if (!carry_n)
            upper <= up_down ? upper + 4'h1 : upper - 4'h1;
    end
endmodule

// [testbench/updown_counter_tb_top.sv]
// self-checking bench for the up/down counter
// assumes the checker binds itself to the design
`timescale 1ns/100ps
module updown_counter_tb_top
    import updown_counter_pkg::*;
;
    logic clk = 0, reset_n = 0, wr = 0, rd = 0;
    ctrl_pins_t pins = 8'hF0;
    logic [3:0] addr = 4'h0, count, upper;
    logic [31:0] wdata = 32'h0, rdata;
    logic low_order_bit, carry_n;
    int errors = 0, checked = 0;
    logic [7:0] pv [12] = '{8'h1E, 8'h90, 8'h90, 8'h90, 8'h80, 8'h80,
        8'hC0, 8'hC0, 8'hD0, 8'hB0, 8'h13, 8'hB0};
    logic [4:0] ev [12] = '{5'h10, 5'h1E, 5'h0F, 5'h10, 5'h11, 5'h00,
        5'h1F, 5'h1F, 5'h0F, 5'h1F, 5'h0F, 5'h13};
    always #5 clk = ~clk;
    updown_counter updown_counter_i (.clk(clk), .reset_n(reset_n),
        .pins(pins), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .count(count), .low_order_bit(low_order_bit),
        .carry_n(carry_n));
    cascade_stage_model cascade_stage_model_i (.clk(clk),
        .reset_n(reset_n), .carry_n(carry_n), .up_down(pins.up_down),
        .upper(upper));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 if (!w) chk(rdata, d);
    endtask
    task test_done;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            pins <= pv[i];
            #1 chk(32'({carry_n, count}), 32'(ev[i]));
            chk(32'(low_order_bit), 32'(ev[i][0]));
        end
        chk(32'(upper), 32'h2);
        bus(1'b1, REG_PRESET, 32'h9);
        bus(1'b0, REG_STATUS, 32'h39);
        bus(1'b0, 4'h8, 32'h0);
        test_done;
    end
    initial begin
        #2000;
        errors++;
        test_done;
    end
endmodule
